// >>> hw/bmu_top.sv
`default_nettype none
module bmu_top
	import bmu_pkg::*;
(
	input wire logic clk_sys, // System clock, 10 MHz
	input wire logic rst_b, // Asynchronous reset, active low
	input wire logic op_valid, // Decoder presents an instruction
	input wire logic [BMU_OP_W-1:0] op_code, // Operation code
	input wire logic idx_from_reg, // Bit index comes from a register
	input wire logic [BMU_IDX_W-1:0] imm_index, // Immediate bit index
	input wire logic [BMU_DATA_W-1:0] index_reg_val, // Register holding bit index
	input wire logic target_mem, // Operand is a memory byte
	input wire logic [BMU_DATA_W-1:0] reg_operand, // Register operand byte
	input wire logic [BMU_ADDR_W-1:0] ea_addr, // Memory operand address
	input wire logic carry_flag_in, // Current carry flag
	input wire logic [BMU_DATA_W-1:0] mem_rd_data, // Read data
	input wire logic mem_rd_ack, // Read data valid
	input wire logic mem_wr_ack, // Write accepted
	output logic op_ready, // Unit can take an instruction
	output logic mem_rd_req, // Memory read request
	output logic mem_wr_req, // Memory write request
	output logic [BMU_ADDR_W-1:0] mem_addr, // Memory address
	output logic [BMU_DATA_W-1:0] mem_wr_data, // Memory write data
	output logic reg_wr_en, // Register write strobe
	output logic [BMU_DATA_W-1:0] reg_wr_data, // Register write data
	output logic carry_we, // Carry flag write strobe
	output logic carry_out, // New carry flag
	output logic zero_we, // Zero flag write strobe
	output logic zero_out, // New zero flag
	output logic op_done, // Instruction finished
	output logic op_illegal // Instruction refused
);
	////////////////////////////////////////////////////////////////////////
	// Reset release

	logic [1:0] rst_sync_reg;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= BMU_RST_SYNC_RST;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Instruction latch

	bmu_state_e state_reg;
	bmu_state_e state_next;
	bmu_op_e op_reg;
	logic [BMU_IDX_W-1:0] idx_reg;
	logic mem_tgt_reg;
	logic carry_reg;
	logic [BMU_DATA_W-1:0] operand_reg;
	logic accept;
	logic refuse;
	logic [BMU_IDX_W-1:0] idx_next;
	bmu_op_e op_in;
	logic rd_take;

	assign op_in = bmu_op_e'(op_code);
	// Follows the advertised ready, not the state: just after reset the state
	// is idle a cycle before op_ready rises, and nothing may be taken then
	assign accept = op_ready && op_valid;
	// Register index with an inverted form, or an unknown code, is refused
	assign refuse = accept && (!bmu_op_legal(op_in) ||
		(idx_from_reg && bmu_op_inverted(op_in)));
	assign idx_next = idx_from_reg ? index_reg_val[BMU_IDX_W-1:0] : imm_index;
	assign rd_take = (state_reg == BMU_ST_MEM_RD) && mem_rd_ack;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_reg <= set_bit_op;
			idx_reg <= BMU_IDX_RST;
		end else if (accept) begin
			op_reg <= op_in;
			idx_reg <= idx_next;
		end
	end

	// Carry is frozen at accept so a flag update by the core mid-op cannot leak in
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_tgt_reg <= 1'b0;
			carry_reg <= 1'b0;
		end else if (accept) begin
			mem_tgt_reg <= target_mem;
			carry_reg <= carry_flag_in;
		end
	end

	// Register operands are latched at accept; memory bytes when read returns
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			operand_reg <= BMU_BYTE_RST;
		end else if (accept) begin
			operand_reg <= reg_operand;
		end else if (rd_take) begin
			operand_reg <= mem_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Datapath

	logic [BMU_DATA_W-1:0] alu_result;
	logic alu_carry;
	logic alu_carry_wr;
	logic alu_zero;
	logic alu_zero_wr;
	logic [BMU_DATA_W-1:0] alu_operand;

	// The byte from memory feeds the ALU in the cycle it arrives, so the
	// modified byte is ready when the write request goes up
	assign alu_operand = rd_take ? mem_rd_data : operand_reg;

	bmu_bit_alu u_alu (
		.op(op_reg),
		.operand(alu_operand),
		.bit_idx(idx_reg),
		.carry_in(carry_reg),
		.result(alu_result),
		.carry_res(alu_carry),
		.carry_wr(alu_carry_wr),
		.zero_res(alu_zero),
		.zero_wr(alu_zero_wr)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BMU_ST_IDLE: begin
				if (accept && !refuse) begin
					state_next = target_mem ? BMU_ST_MEM_RD : BMU_ST_DONE;
				end
			end
			BMU_ST_MEM_RD: begin
				if (mem_rd_ack) begin
					// Read-only operations never write the byte back
					state_next = bmu_op_writes_byte(op_reg) ? BMU_ST_MEM_WR : BMU_ST_DONE;
				end
			end
			BMU_ST_MEM_WR: begin
				if (mem_wr_ack) begin
					state_next = BMU_ST_DONE;
				end
			end
			BMU_ST_DONE: begin
				state_next = BMU_ST_IDLE;
			end
			default: begin
				state_next = BMU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= BMU_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_ready <= 1'b0;
		end else begin
			op_ready <= (state_next == BMU_ST_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory path

	// Requests stand until the edge after their acknowledge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_rd_req <= 1'b0;
		end else begin
			mem_rd_req <= (state_next == BMU_ST_MEM_RD);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_wr_req <= 1'b0;
		end else begin
			mem_wr_req <= (state_next == BMU_ST_MEM_WR);
		end
	end

	// Address is held for the whole read-modify-write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr <= BMU_ADDR_RST;
		end else if (accept) begin
			mem_addr <= ea_addr;
		end
	end

	// Full byte with one bit changed is valid from the first write request cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mem_wr_data <= BMU_BYTE_RST;
		end else if (rd_take) begin
			mem_wr_data <= alu_result;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Results

	logic finish;

	assign finish = (state_reg == BMU_ST_DONE);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_wr_en <= 1'b0;
		end else begin
			reg_wr_en <= finish && !mem_tgt_reg && bmu_op_writes_byte(op_reg);
		end
	end

	// Result byte holds until the next instruction finishes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_wr_data <= BMU_BYTE_RST;
		end else if (finish) begin
			reg_wr_data <= alu_result;
		end
	end

	// Each flag strobe fires only for the flag the operation names
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			carry_we <= 1'b0;
			carry_out <= 1'b0;
		end else begin
			carry_we <= finish && alu_carry_wr;
			if (finish) begin
				carry_out <= alu_carry;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			zero_we <= 1'b0;
			zero_out <= 1'b0;
		end else begin
			zero_we <= finish && alu_zero_wr;
			if (finish) begin
				zero_out <= alu_zero;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_done <= 1'b0;
		end else begin
			op_done <= finish || refuse;
		end
	end

	// A refused instruction still finishes, so the decoder never waits on it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			op_illegal <= 1'b0;
		end else begin
			op_illegal <= refuse;
		end
	end
endmodule
`default_nettype wire

// >>> hw/bmu_pkg.sv
`default_nettype none
package bmu_pkg;
	localparam int BMU_DATA_W = 8;
	localparam int BMU_IDX_W = 3;
	localparam int BMU_ADDR_W = 16;
	localparam int BMU_OP_W = 4;
	localparam logic [BMU_DATA_W-1:0] BMU_BYTE_RST = 8'h00;
	localparam logic [BMU_ADDR_W-1:0] BMU_ADDR_RST = 16'h0000;
	localparam logic [BMU_IDX_W-1:0] BMU_IDX_RST = 3'h0;
	localparam logic [1:0] BMU_RST_SYNC_RST = 2'h0;

	typedef enum logic [BMU_OP_W-1:0] {
		set_bit_op = 4'h0,
		clear_bit_op = 4'h1,
		invert_bit_op = 4'h2,
		test_bit_op = 4'h3,
		carry_and_bit_op = 4'h4,
		carry_and_inverted_bit_op = 4'h5,
		carry_or_bit_op = 4'h6,
		carry_or_inverted_bit_op = 4'h7,
		carry_xor_bit_op = 4'h8,
		carry_xor_inverted_bit_op = 4'h9,
		bit_to_carry_op = 4'ha,
		inverted_bit_to_carry_op = 4'hb,
		carry_to_bit_op = 4'hc,
		inverted_carry_to_bit_op = 4'hd
	} bmu_op_e;

	typedef enum logic [3:0] {
		BMU_ST_IDLE = 4'h1,
		BMU_ST_MEM_RD = 4'h2,
		BMU_ST_MEM_WR = 4'h4,
		BMU_ST_DONE = 4'h8
	} bmu_state_e;

	// Inverted-operand forms only exist with an immediate bit index
	function automatic logic bmu_op_inverted(input bmu_op_e op);
		return (op == carry_and_inverted_bit_op) || (op == carry_or_inverted_bit_op) ||
			(op == carry_xor_inverted_bit_op) || (op == inverted_bit_to_carry_op) ||
			(op == inverted_carry_to_bit_op);
	endfunction

	function automatic logic bmu_op_writes_byte(input bmu_op_e op);
		return (op == set_bit_op) || (op == clear_bit_op) || (op == invert_bit_op) ||
			(op == carry_to_bit_op) || (op == inverted_carry_to_bit_op);
	endfunction

	function automatic logic bmu_op_legal(input bmu_op_e op);
		return op <= inverted_carry_to_bit_op;
	endfunction
endpackage
`default_nettype wire

// >>> hw/bmu_bit_alu.sv
`default_nettype none
module bmu_bit_alu
	import bmu_pkg::*;
(
	input wire bmu_op_e op, // Operation
	input wire logic [BMU_DATA_W-1:0] operand, // Byte operand
	input wire logic [BMU_IDX_W-1:0] bit_idx, // Selected bit
	input wire logic carry_in, // Current carry flag
	output logic [BMU_DATA_W-1:0] result, // Modified byte
	output logic carry_res, // New carry value
	output logic carry_wr, // Carry is updated
	output logic zero_res, // New zero value
	output logic zero_wr // Zero is updated
);
	logic sel_bit;
	logic [BMU_DATA_W-1:0] mask;

	always_comb begin
		mask = BMU_BYTE_RST;
		mask[bit_idx] = 1'b1;
		sel_bit = operand[bit_idx];
	end

	// Only the selected bit is ever touched; other seven pass through
	always_comb begin
		result = operand;
		case (op)
			set_bit_op: result = operand | mask;
			clear_bit_op: result = operand & ~mask;
			invert_bit_op: result = operand ^ mask;
			carry_to_bit_op: result = carry_in ? (operand | mask) : (operand & ~mask);
			inverted_carry_to_bit_op: result = carry_in ? (operand & ~mask) : (operand | mask);
			default: result = operand;
		endcase
	end

	always_comb begin
		carry_res = carry_in;
		carry_wr = 1'b0;
		zero_res = 1'b0;
		zero_wr = 1'b0;
		case (op)
			test_bit_op: begin
				zero_res = ~sel_bit;
				zero_wr = 1'b1;
			end
			carry_and_bit_op: begin
				carry_res = carry_in & sel_bit;
				carry_wr = 1'b1;
			end
			carry_and_inverted_bit_op: begin
				carry_res = carry_in & ~sel_bit;
				carry_wr = 1'b1;
			end
			carry_or_bit_op: begin
				carry_res = carry_in | sel_bit;
				carry_wr = 1'b1;
			end
			carry_or_inverted_bit_op: begin
				carry_res = carry_in | ~sel_bit;
				carry_wr = 1'b1;
			end
			carry_xor_bit_op: begin
				carry_res = carry_in ^ sel_bit;
				carry_wr = 1'b1;
			end
			carry_xor_inverted_bit_op: begin
				carry_res = carry_in ^ ~sel_bit;
				carry_wr = 1'b1;
			end
			bit_to_carry_op: begin
				carry_res = sel_bit;
				carry_wr = 1'b1;
			end
			inverted_bit_to_carry_op: begin
				carry_res = ~sel_bit;
				carry_wr = 1'b1;
			end
			default: begin
				carry_res = carry_in;
				carry_wr = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> bench/bmu_top_sva.sv
`default_nettype none
module bmu_top_chk
	import bmu_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic rst_b, // Reset, active low
	input wire logic op_valid, // Instruction offered
	input wire logic [BMU_OP_W-1:0] op_code, // Operation
	input wire logic idx_from_reg, // Index source
	input wire logic target_mem, // Memory operand
	input wire logic mem_rd_ack, // Read done
	input wire logic mem_wr_ack, // Write done
	input wire logic op_ready, // Idle
	input wire logic mem_rd_req, // Read request
	input wire logic mem_wr_req, // Write request
	input wire logic [BMU_ADDR_W-1:0] mem_addr, // Address
	input wire logic [BMU_DATA_W-1:0] mem_wr_data, // Write data
	input wire logic reg_wr_en, // Register write
	input wire logic carry_we, // Carry write
	input wire logic zero_we, // Zero write
	input wire logic op_done, // Finished
	input wire logic op_illegal // Refused
);
	logic inv_op;
	logic bad_op;
	logic take;
	assign inv_op = op_code[0] && (op_code >= 4'h5) && (op_code <= 4'hd);
	assign bad_op = (op_code > 4'hd) || (inv_op && idx_from_reg);
	assign take = op_valid && op_ready;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_rd_end; mem_rd_req && mem_rd_ack; endsequence
	sequence s_wr_end; mem_wr_req && mem_wr_ack; endsequence
	property p_refuse; take && bad_op |=> op_done && op_illegal; endproperty
	a_refuse: assert property (p_refuse) else $error("refused op not flagged");
	property p_ill_quiet;
		op_illegal |-> !carry_we && !zero_we && !reg_wr_en && !mem_rd_req;
	endproperty
	a_ill_quiet: assert property (p_ill_quiet) else $error("refused op had effect");
	property p_reg_lat;
		take && !bad_op && !target_mem |=> !op_done ##1 (op_done && !mem_rd_req);
	endproperty
	a_reg_lat: assert property (p_reg_lat) else $error("register op latency wrong");
	property p_mem_start; take && !bad_op && target_mem |=> ##[0:1] mem_rd_req; endproperty
	a_mem_start: assert property (p_mem_start) else $error("memory op did not read");
	property p_rd_end; s_rd_end |=> !mem_rd_req ##1 (op_done ^ mem_wr_req); endproperty
	a_rd_end: assert property (p_rd_end) else $error("read end sequence wrong");
	property p_wr_end; s_wr_end |=> !mem_wr_req ##1 op_done; endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end sequence wrong");
	property p_wr_after_rd; $rose(mem_wr_req) |-> $past(mem_rd_req) && !mem_rd_req; endproperty
	a_wr_after_rd: assert property (p_wr_after_rd) else $error("write not after read");
	property p_addr_hold; mem_wr_req |-> $stable(mem_addr); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
	property p_wr_data_hold;
		mem_wr_req && $past(mem_wr_req) |-> $stable(mem_wr_data);
	endproperty
	a_wr_data_hold: assert property (p_wr_data_hold) else $error("write data moved");
	property p_one_flag; zero_we |-> op_done && !carry_we && !reg_wr_en; endproperty
	a_one_flag: assert property (p_one_flag) else $error("test op touched more");
	property p_carry_only; carry_we |-> op_done && !zero_we && !reg_wr_en; endproperty
	a_carry_only: assert property (p_carry_only) else $error("carry op touched more");
endmodule
bind bmu_top bmu_top_chk bmu_top_chk_i (.clk_sys, .rst_b, .op_valid, .op_code, .idx_from_reg,
	.target_mem, .mem_rd_ack, .mem_wr_ack, .op_ready, .mem_rd_req, .mem_wr_req, .mem_addr,
	.mem_wr_data, .reg_wr_en, .carry_we, .zero_we, .op_done, .op_illegal);
`default_nettype wire

// >>> bench/bmu_mem_model.sv
`default_nettype none
module bmu_mem_model (
	input wire logic clk_sys, // Clock
	input wire logic mem_rd_req, // Read request
	input wire logic mem_wr_req, // Write request
	input wire logic [15:0] mem_addr, // Address
	input wire logic [7:0] mem_wr_data, // Write data
	output logic [7:0] mem_rd_data, // Read data
	output logic mem_rd_ack, // Read done
	output logic mem_wr_ack // Write done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem_byte [0:15];
	logic [1:0] wait_cnt = 2'h0;
	initial begin
		mem_rd_data = 8'h00;
		mem_rd_ack = 1'b0;
		mem_wr_ack = 1'b0;
	end
	// Latency follows the address so prompt and slow answers both occur
	always @(posedge clk_sys) begin
		mem_rd_ack <= 1'b0;
		mem_wr_ack <= 1'b0;
		mem_rd_data <= ~mem_rd_data; // Stale data never looks valid
		if (mem_wr_req && mem_wr_ack)
			mem_byte[mem_addr[3:0]] <= mem_wr_data;
		if ((mem_rd_req || mem_wr_req) && !mem_rd_ack && !mem_wr_ack) begin
			if (wait_cnt == mem_addr[1:0]) begin
				wait_cnt <= 2'h0;
				mem_rd_ack <= mem_rd_req;
				mem_wr_ack <= !mem_rd_req;
				if (mem_rd_req)
					mem_rd_data <= mem_byte[mem_addr[3:0]];
			end else
				wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

// >>> bench/bmu_top_test.sv
`default_nettype none
module bmu_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic ill, rw, cw, c, zw, z, tm;
		logic [7:0] val;
		logic [3:0] a;
	} bmu_note_s;
	logic clk_sys = 1'b0, rst_b = 1'b0, op_valid = 1'b0, idx_from_reg = 1'b0;
	logic target_mem = 1'b0, carry_flag_in = 1'b0;
	logic [3:0] op_code = 4'h0;
	logic [2:0] imm_index = 3'h0;
	logic [7:0] index_reg_val = 8'h00, reg_operand = 8'h00, mem_rd_data, mem_wr_data, reg_wr_data;
	logic [15:0] ea_addr = 16'h0000, mem_addr;
	logic op_ready, mem_rd_req, mem_wr_req, reg_wr_en, carry_we, carry_out, zero_we, zero_out;
	logic op_done, op_illegal, mem_rd_ack, mem_wr_ack;
	bmu_note_s note_q[$];
	bmu_note_s m;
	int fail_count = 0, n_compared = 0, seed = 81494;
	bmu_top bmu_top_i (.clk_sys, .rst_b, .op_valid, .op_code, .idx_from_reg, .imm_index,
		.index_reg_val, .target_mem, .reg_operand, .ea_addr, .carry_flag_in, .mem_rd_data,
		.mem_rd_ack, .mem_wr_ack, .op_ready, .mem_rd_req, .mem_wr_req, .mem_addr, .mem_wr_data,
		.reg_wr_en, .reg_wr_data, .carry_we, .carry_out, .zero_we, .zero_out, .op_done, .op_illegal);
	bmu_mem_model bmu_mem_model_i (.clk_sys, .mem_rd_req, .mem_wr_req, .mem_addr, .mem_wr_data,
		.mem_rd_data, .mem_rd_ack, .mem_wr_ack);
	initial forever #50 clk_sys = ~clk_sys;
	task end_of_test();
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// The unused index source and operand get other values so a wrong pick shows
	task run_op(input logic [3:0] op, input logic ir, input logic tm);
		logic [7:0] v;
		logic [2:0] ix;
		logic c;
		logic b;
		int k;
		bmu_note_s n;
		k = 0;
		do @(negedge clk_sys) k++; while (op_ready !== 1'b1 && k < 100);
		@(posedge clk_sys);
		v = 8'($random(seed));
		ix = 3'($random(seed));
		c = 1'($random(seed));
		k = $random(seed);
		n = '0;
		n.a = 4'(k);
		n.tm = tm;
		n.val = v;
		bmu_mem_model_i.mem_byte[n.a] = tm ? v : ~v;
		op_code <= op;
		idx_from_reg <= ir;
		target_mem <= tm;
		imm_index <= ir ? ~ix : ix;
		index_reg_val <= ir ? {k[11:7], ix} : {k[11:7], ~ix};
		reg_operand <= tm ? ~v : v;
		ea_addr <= {k[15:4], n.a};
		carry_flag_in <= c;
		op_valid <= 1'b1;
		b = v[ix];
		n.ill = (op > 4'hd) || (ir && op[0] && op >= 4'h5);
		n.rw = op inside {4'h0, 4'h1, 4'h2, 4'hc, 4'hd};
		n.cw = op inside {[4'h4:4'hb]};
		n.zw = op == 4'h3;
		case (op)
			4'h0: n.val[ix] = 1'b1;
			4'h1: n.val[ix] = 1'b0;
			4'h2: n.val[ix] = ~b;
			4'h3: n.z = ~b;
			4'h4: n.c = c & b;
			4'h5: n.c = c & ~b;
			4'h6: n.c = c | b;
			4'h7: n.c = c | ~b;
			4'h8: n.c = c ^ b;
			4'h9: n.c = c ^ ~b;
			4'ha: n.c = b;
			4'hb: n.c = ~b;
			4'hc: n.val[ix] = c;
			4'hd: n.val[ix] = ~c;
			default: ;
		endcase
		if (n.ill) begin
			n.rw = 1'b0;
			n.cw = 1'b0;
			n.zw = 1'b0;
			n.val = v;
		end
		note_q.push_back(n);
		@(posedge clk_sys);
		op_valid <= 1'b0;
	endtask
	always @(negedge clk_sys) begin
		if (op_done === 1'b1) begin
			check(8'(note_q.size() != 0), 8'h01);
			m = note_q.pop_front();
			check(8'(op_illegal), 8'(m.ill));
			check(8'(reg_wr_en), 8'(m.rw && !m.tm));
			if (m.tm)
				check(bmu_mem_model_i.mem_byte[m.a], m.val);
			else if (m.rw)
				check(reg_wr_data, m.val);
			check(8'(carry_we), 8'(m.cw));
			if (m.cw)
				check(8'(carry_out), 8'(m.c));
			check(8'(zero_we), 8'(m.zw));
			if (m.zw)
				check(8'(zero_out), 8'(m.z));
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 64; i++)
			run_op(4'(i), i[4], i[5]);
		for (int i = 0; i < 80; i++)
			run_op(4'($random(seed)), 1'($random(seed)), 1'($random(seed)));
		repeat (20) @(posedge clk_sys);
		check(8'(note_q.size()), 8'h00);
		end_of_test();
	end
	initial begin
		repeat (6000) @(posedge clk_sys);
		fail_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
